/* File: rtl/acgc_ctrl.sv */
// converter control: commands, calibration, modes, correction and pins
`timescale 1ns/1ns
`default_nettype none
module acgc_ctrl #(
  parameter int unsigned SELF_CAL_CYCLES = acgc_pkg::SELF_CAL_CYC,
  parameter int unsigned SYS_CAL_CYCLES = acgc_pkg::SYS_CAL_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // conversion link clock from the modulator
  input wire logic link_clock_in,
  // command byte strobe
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  // register write port
  input wire logic reg_we_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [23:0] reg_wdata_in,
  // modulator sample on link clock
  input wire logic sample_valid_in,
  input wire logic [23:0] sample_in,
  // general-purpose pins
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe_out,
  // configuration outputs
  output logic [7:0] converter_setup_out,
  output logic [7:0] trim_control_out,
  output logic [7:0] pin_control_out,
  output logic [2:0] rate_out,
  output logic reference_buffer_enable_out,
  output logic signal_buffer_enable_out,
  output logic oscillator_select_out,
  output logic outside_clock_select_out,
  output logic single_shot_select_out,
  output logic power_down_out,
  // status and coefficients
  output logic busy_out,
  output logic [3:0] gpio_level_out,
  output logic [23:0] soc_out,
  output logic [23:0] sgc_out,
  output logic [23:0] scoc_out,
  output logic [23:0] scgc_out,
  // corrected result
  output logic result_valid_out,
  output logic result_settled_out,
  output logic [23:0] result_out
);
  typedef struct packed {
    acgc_pkg::acgc_state_t state_reg;
    logic [1:0] kind_reg;
    logic [31:0] count_reg;
    logic [7:0] setup_reg;
    logic [7:0] trim_reg;
    logic [7:0] pin_reg;
    logic [2:0] rate_reg;
    logic pd_reg;
    logic [23:0] soc_reg;
    logic [23:0] sgc_reg;
    logic [23:0] scoc_reg;
    logic [23:0] scgc_reg;
    logic [23:0] zero_reg;
    logic [1:0] settle_reg;
    logic res_set_reg;
    logic [23:0] last_raw_reg;
    logic stog_seen_reg;
    logic res_valid_reg;
    logic [23:0] res_reg;
  } acgc_main_t;
  typedef struct packed {
    logic [23:0] data_reg;
    logic tog_reg;
  } acgc_link_t;
  acgc_main_t st_reg;
  acgc_main_t st_next;
  acgc_link_t lk_reg;
  acgc_link_t lk_next;
  logic tog_sync;
  logic [3:0] gpio_sync;
  // clamp a gain word into half to one and a half
  function automatic logic [23:0] clamp_gain(input logic [23:0] g);
    if (g < acgc_pkg::GAIN_MIN) begin
      clamp_gain = acgc_pkg::GAIN_MIN;
    end else if (g > acgc_pkg::GAIN_MAX) begin
      clamp_gain = acgc_pkg::GAIN_MAX;
    end else begin
      clamp_gain = g;
    end
  endfunction
  // clamp an offset word into a quarter of the reference
  function automatic logic [23:0] clamp_off(input logic [23:0] o);
    logic signed [24:0] s;
    s = 25'(signed'(o));
    if (s > acgc_pkg::OFF_MAX) begin
      clamp_off = acgc_pkg::OFF_MAX[23:0];
    end else if (s < acgc_pkg::OFF_MIN) begin
      clamp_off = acgc_pkg::OFF_MIN[23:0];
    end else begin
      clamp_off = o;
    end
  endfunction
  // subtract half-lsb offset then scale by 1.23 gain
  function automatic logic [23:0] trim(input logic [23:0] x, input logic [23:0] off,
                                       input logic [23:0] gain, input logic use_off,
                                       input logic use_gain);
    logic [48:0] p;
    logic [24:0] y;
    p = '0;
    y = {1'b0, x};
    if (use_off) begin
      y = 25'({1'b0, x} - 25'(off[23:1]));
    end
    if (use_gain) begin
      p = 49'(y[23:0]) * 49'(gain);
      y = 25'(p[46:23]);
    end
    trim = y[23:0];
  endfunction
  // ==========================================================
  // link domain capture
  always_comb begin
    lk_next = lk_reg;
    if (sample_valid_in) begin
      lk_next.data_reg = sample_in;
      lk_next.tog_reg = ~lk_reg.tog_reg;
    end
  end
  always_ff @(posedge link_clock_in or posedge rst_in) begin
    if (rst_in) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end
  acgc_sync #(.W(1)) u_tog_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .d_in(lk_reg.tog_reg),
    .q_out(tog_sync)
  );
  acgc_sync #(.W(4)) u_pin_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .d_in(gpio_in),
    .q_out(gpio_sync)
  );
  // ==========================================================
  // main control
  logic new_sample;
  logic [23:0] raw;
  logic [23:0] cal_val;
  always_comb begin
    st_next = st_reg;
    new_sample = tog_sync != st_reg.stog_seen_reg;
    // data word is stable for several link cycles after the toggle arrives
    raw = 24'(({24'h0, lk_reg.data_reg} * 48'(acgc_pkg::RAW_SCALE)) >> 23);
    cal_val = '0;
    st_next.stog_seen_reg = tog_sync;
    st_next.res_valid_reg = 1'b0;
    // sample word held in this domain once its toggle has crossed
    if (new_sample) begin
      st_next.last_raw_reg = raw;
    end
    if (reg_we_in && st_reg.state_reg != acgc_pkg::ST_CAL) begin
      unique case (reg_sel_in)
        acgc_pkg::SEL_SETUP: st_next.setup_reg = reg_wdata_in[7:0];
        acgc_pkg::SEL_PIN: st_next.pin_reg = reg_wdata_in[7:0];
        acgc_pkg::SEL_TRIM: st_next.trim_reg = reg_wdata_in[7:0];
        acgc_pkg::SEL_SOC: st_next.soc_reg = clamp_off(reg_wdata_in);
        acgc_pkg::SEL_SGC: st_next.sgc_reg = clamp_gain(reg_wdata_in);
        acgc_pkg::SEL_SCOC: st_next.scoc_reg = clamp_off(reg_wdata_in);
        acgc_pkg::SEL_SCGC: st_next.scgc_reg = clamp_gain(reg_wdata_in);
        default: st_next.pin_reg = st_reg.pin_reg;
      endcase
    end
    unique case (st_reg.state_reg)
      acgc_pkg::ST_IDLE, acgc_pkg::ST_CONV: begin
        if (cmd_valid_in && cmd_byte_in[acgc_pkg::CMD_START_BIT]
            && !cmd_byte_in[acgc_pkg::CMD_MODE_BIT]) begin
          st_next.rate_reg = cmd_byte_in[acgc_pkg::CMD_RATE_HI:0];
          st_next.pd_reg = cmd_byte_in[acgc_pkg::CMD_PD_BIT];
          st_next.kind_reg = cmd_byte_in[acgc_pkg::CMD_CAL_HI:acgc_pkg::CMD_CAL_LO];
          st_next.settle_reg = 2'(acgc_pkg::SETTLE_EXTRA);
          st_next.count_reg = '0;
          if (cmd_byte_in[acgc_pkg::CMD_PD_BIT]) begin
            st_next.state_reg = acgc_pkg::ST_IDLE;
          end else if (cmd_byte_in[acgc_pkg::CMD_CAL_HI:acgc_pkg::CMD_CAL_LO]
                       != acgc_pkg::CAL_NONE) begin
            st_next.state_reg = acgc_pkg::ST_CAL;
          end else begin
            st_next.state_reg = acgc_pkg::ST_CONV;
          end
        end else if (st_reg.state_reg == acgc_pkg::ST_CONV && new_sample) begin
          st_next.res_reg = trim(trim(raw, st_reg.scoc_reg, st_reg.scgc_reg,
                                      !st_reg.trim_reg[acgc_pkg::TC_SELF_OFF],
                                      !st_reg.trim_reg[acgc_pkg::TC_SELF_GAIN]),
                                 st_reg.soc_reg, st_reg.sgc_reg,
                                 !st_reg.trim_reg[acgc_pkg::TC_SYS_OFF],
                                 !st_reg.trim_reg[acgc_pkg::TC_SYS_GAIN]);
          st_next.res_valid_reg = 1'b1;
          st_next.res_set_reg = (st_reg.settle_reg == 2'h0)
                                || st_reg.setup_reg[acgc_pkg::SU_SHOT_BIT];
          if (st_reg.settle_reg != 2'h0 && !st_reg.setup_reg[acgc_pkg::SU_SHOT_BIT]) begin
            st_next.settle_reg = st_reg.settle_reg - 2'h1;
          end else begin
            st_next.settle_reg = 2'h0;
          end
          if (st_reg.setup_reg[acgc_pkg::SU_SHOT_BIT]) begin
            st_next.state_reg = acgc_pkg::ST_IDLE;
          end
        end
      end
      acgc_pkg::ST_CAL: begin
        st_next.count_reg = st_reg.count_reg + 32'h1;
        if (new_sample && st_reg.kind_reg == acgc_pkg::CAL_SELF
            && st_reg.count_reg < 32'(SELF_CAL_CYCLES / 2)) begin
          st_next.zero_reg = raw;
        end
        if ((st_reg.kind_reg == acgc_pkg::CAL_SELF
             && st_reg.count_reg == 32'(SELF_CAL_CYCLES - 1))
            || (st_reg.kind_reg != acgc_pkg::CAL_SELF
                && st_reg.count_reg == 32'(SYS_CAL_CYCLES - 1))) begin
          st_next.state_reg = acgc_pkg::ST_IDLE;
          unique case (st_reg.kind_reg)
            acgc_pkg::CAL_SELF: begin
              st_next.scoc_reg = clamp_off({st_reg.zero_reg[22:0], 1'b0});
              st_next.scgc_reg = acgc_pkg::GAIN_UNITY;
            end
            acgc_pkg::CAL_SYS_ZERO: begin
              cal_val = clamp_off({st_reg.last_raw_reg[22:0], 1'b0});
              st_next.soc_reg = cal_val;
            end
            default: begin
              cal_val = (st_reg.last_raw_reg == 24'h0) ? acgc_pkg::GAIN_MAX :
                        clamp_gain(24'((48'(acgc_pkg::RAW_SCALE) << 23)
                                       / 48'(st_reg.last_raw_reg)));
              st_next.sgc_reg = cal_val;
            end
          endcase
        end
      end
      default: st_next.state_reg = acgc_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.state_reg <= acgc_pkg::ST_IDLE;
      st_reg.setup_reg <= acgc_pkg::SETUP_RESET;
      st_reg.trim_reg <= acgc_pkg::TRIM_RESET;
      st_reg.pin_reg <= acgc_pkg::PIN_RESET;
      st_reg.soc_reg <= acgc_pkg::COEF_RESET;
      st_reg.sgc_reg <= acgc_pkg::COEF_RESET;
      st_reg.scoc_reg <= acgc_pkg::COEF_RESET;
      st_reg.scgc_reg <= acgc_pkg::COEF_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
  // ==========================================================
  // output flops
  typedef struct packed {
    logic [3:0] gout_reg;
    logic [3:0] goe_reg;
    logic [3:0] glev_reg;
    logic busy_reg;
  } acgc_out_t;
  acgc_out_t o_reg;
  acgc_out_t o_next;
  always_comb begin
    o_next = o_reg;
    o_next.goe_reg = st_next.pin_reg[7:4];
    o_next.gout_reg = st_next.pin_reg[3:0] & st_next.pin_reg[7:4];
    o_next.glev_reg = gpio_sync;
    o_next.busy_reg = st_next.state_reg != acgc_pkg::ST_IDLE;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      o_reg <= '0;
    end else begin
      o_reg <= o_next;
    end
  end
  assign gpio_out = o_reg.gout_reg;
  assign gpio_oe_out = o_reg.goe_reg;
  assign gpio_level_out = o_reg.glev_reg;
  assign busy_out = o_reg.busy_reg;
  assign converter_setup_out = st_reg.setup_reg;
  assign trim_control_out = st_reg.trim_reg;
  assign pin_control_out = st_reg.pin_reg;
  assign rate_out = st_reg.rate_reg;
  assign reference_buffer_enable_out = st_reg.setup_reg[acgc_pkg::SU_REFERENCE_BUFFER_ENABLE_BIT];
  assign signal_buffer_enable_out = st_reg.setup_reg[acgc_pkg::SU_SIGNAL_BUFFER_ENABLE_BIT];
  assign oscillator_select_out = st_reg.setup_reg[acgc_pkg::SU_OSC_BIT];
  assign outside_clock_select_out = st_reg.setup_reg[acgc_pkg::SU_OUTCLK_BIT];
  assign single_shot_select_out = st_reg.setup_reg[acgc_pkg::SU_SHOT_BIT];
  assign power_down_out = st_reg.pd_reg;
  assign soc_out = st_reg.soc_reg;
  assign sgc_out = st_reg.sgc_reg;
  assign scoc_out = st_reg.scoc_reg;
  assign scgc_out = st_reg.scgc_reg;
  assign result_valid_out = st_reg.res_valid_reg;
  assign result_settled_out = st_reg.res_set_reg;
  assign result_out = st_reg.res_reg;
endmodule // acgc_ctrl
`default_nettype wire

/* File: rtl/acgc_pkg.sv */
// constants, types and register layouts for the converter control block
package acgc_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SELF_CAL_MS = 200;
  localparam int unsigned SYS_CAL_MS = 100;
  localparam int unsigned SELF_CAL_CYC = SELF_CAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned SYS_CAL_CYC = SYS_CAL_MS * 1000 * CLK_MHZ;
  // command byte fields
  localparam int unsigned CMD_START_BIT = 7;
  localparam int unsigned CMD_MODE_BIT = 6;
  localparam int unsigned CMD_CAL_HI = 5;
  localparam int unsigned CMD_CAL_LO = 4;
  localparam int unsigned CMD_PD_BIT = 3;
  localparam int unsigned CMD_RATE_HI = 2;
  localparam logic [1:0] CAL_SELF = 2'h1;
  localparam logic [1:0] CAL_SYS_ZERO = 2'h2;
  localparam logic [1:0] CAL_SYS_FULL = 2'h3;
  localparam logic [1:0] CAL_NONE = 2'h0;
  // setup register bits
  localparam int unsigned SU_OSC_BIT = 1;
  localparam int unsigned SU_OUTCLK_BIT = 2;
  localparam int unsigned SU_REFERENCE_BUFFER_ENABLE_BIT = 3;
  localparam int unsigned SU_SIGNAL_BUFFER_ENABLE_BIT = 4;
  localparam int unsigned SU_SHOT_BIT = 0;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  // trim control: bypass bits self offset, self gain, sys offset, sys gain
  localparam int unsigned TC_SELF_OFF = 0;
  localparam int unsigned TC_SELF_GAIN = 1;
  localparam int unsigned TC_SYS_OFF = 2;
  localparam int unsigned TC_SYS_GAIN = 3;
  localparam logic [7:0] TRIM_RESET = 8'h0f;
  localparam logic [7:0] PIN_RESET = 8'h00;
  localparam logic [23:0] COEF_RESET = 24'h000000;
  // correction limits: gain in 1.23 fixed point, offset in half lsb
  localparam logic [23:0] GAIN_MIN = 24'h400000;
  localparam logic [23:0] GAIN_MAX = 24'hbfffff;
  localparam logic [23:0] GAIN_UNITY = 24'h800000;
  localparam logic signed [24:0] OFF_MAX = 25'sh0800000;
  localparam logic signed [24:0] OFF_MIN = -25'sh0800000;
  // uncorrected full scale is about sixty percent of the code range
  localparam logic [23:0] RAW_SCALE = 24'h4ccccd;
  // register selects on the write port
  localparam logic [2:0] SEL_SETUP = 3'h0;
  localparam logic [2:0] SEL_PIN = 3'h1;
  localparam logic [2:0] SEL_TRIM = 3'h2;
  localparam logic [2:0] SEL_SOC = 3'h3;
  localparam logic [2:0] SEL_SGC = 3'h4;
  localparam logic [2:0] SEL_SCOC = 3'h5;
  localparam logic [2:0] SEL_SCGC = 3'h6;
  localparam int unsigned SETTLE_EXTRA = 3;
  localparam int unsigned CONT_FACTOR_SHIFT = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_CAL, ST_CONV} acgc_state_t;
endpackage

/* File: rtl/acgc_sync.sv */
// two flip-flop synchroniser for level signals
`timescale 1ns/1ns
`default_nettype none
module acgc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
  } acgc_sync_t;
  acgc_sync_t st_reg;
  acgc_sync_t st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1_reg = d_in;
    st_next.s2_reg = st_reg.s1_reg;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q_out = st_reg.s2_reg;
endmodule // acgc_sync
`default_nettype wire

/* File: bench/acgc_ctrl_monitor.sv */
// assertions on the converter control ports
`timescale 1ns/1ns
`default_nettype none
module acgc_ctrl_monitor #(
  parameter int unsigned SELF_CAL_CYCLES = 200,
  parameter int unsigned SYS_CAL_CYCLES = 100
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // requests
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic reg_we_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [23:0] reg_wdata_in,
  // observed outputs
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe_out,
  input wire logic [7:0] converter_setup_out,
  input wire logic [7:0] trim_control_out,
  input wire logic [7:0] pin_control_out,
  input wire logic reference_buffer_enable_out,
  input wire logic signal_buffer_enable_out,
  input wire logic oscillator_select_out,
  input wire logic single_shot_select_out,
  input wire logic busy_out,
  input wire logic [23:0] soc_out,
  input wire logic [23:0] scgc_out
);
  // ==========
  // calibration tracking
  logic cal_on_reg;
  logic self_reg;
  logic [31:0] cnt_reg;
  logic take;
  logic [7:0] trim_w;
  logic [31:0] exp_len;
  assign trim_w = reg_wdata_in[7:0];
  assign exp_len = self_reg ? SELF_CAL_CYCLES : SYS_CAL_CYCLES;
  assign take = cmd_valid_in && !cal_on_reg && cmd_byte_in[7] && !cmd_byte_in[6]
    && !cmd_byte_in[3] && (cmd_byte_in[5:4] != acgc_pkg::CAL_NONE);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cal_on_reg <= 1'b0;
      self_reg <= 1'b0;
      cnt_reg <= 32'h0;
    end else if (take) begin
      cal_on_reg <= 1'b1;
      self_reg <= (cmd_byte_in[5:4] == acgc_pkg::CAL_SELF);
      cnt_reg <= 32'h0;
    end else if (cal_on_reg) begin
      cnt_reg <= cnt_reg + 32'h1;
      if ($fell(busy_out)) begin
        cal_on_reg <= 1'b0;
      end
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_take;
    take;
  endsequence
  sequence s_cal_end;
    cal_on_reg && $fell(busy_out);
  endsequence
  a_gpio_dir_map: assert property (gpio_oe_out == pin_control_out[7:4])
    else $error("pin direction mismatch");
  a_gpio_drive_level: assert property (gpio_out == (pin_control_out[3:0] & gpio_oe_out))
    else $error("pin level mismatch");
  a_shot_osc_bits: assert property (
    (single_shot_select_out == converter_setup_out[acgc_pkg::SU_SHOT_BIT])
    && (oscillator_select_out == converter_setup_out[acgc_pkg::SU_OSC_BIT]))
    else $error("mode bit mismatch");
  a_buffer_bits: assert property (
    (reference_buffer_enable_out == converter_setup_out[acgc_pkg::SU_REFERENCE_BUFFER_ENABLE_BIT])
    && (signal_buffer_enable_out == converter_setup_out[acgc_pkg::SU_SIGNAL_BUFFER_ENABLE_BIT]))
    else $error("buffer bit mismatch");
  a_coef_write: assert property (
    reg_we_in && reg_sel_in == acgc_pkg::SEL_SOC && !cal_on_reg && !take
    |=> soc_out == $past(reg_wdata_in))
    else $error("offset write lost");
  a_trim_write: assert property (
    reg_we_in && reg_sel_in == acgc_pkg::SEL_TRIM && !cal_on_reg && !take
    |=> trim_control_out == $past(trim_w))
    else $error("trim write lost");
  a_cal_start: assert property (s_take |=> busy_out [*3])
    else $error("calibration not busy");
  a_cal_length: assert property (
    s_cal_end |-> (cnt_reg + 32'h1 >= exp_len) && (cnt_reg <= exp_len + 32'h2))
    else $error("calibration length wrong");
  a_self_gain_load: assert property (
    s_cal_end ##0 self_reg |-> scgc_out == acgc_pkg::GAIN_UNITY)
    else $error("self gain not loaded");
  a_cmd_refused: assert property (
    cmd_valid_in && !busy_out && !(cmd_byte_in[7] && !cmd_byte_in[6]) |=> !busy_out)
    else $error("bad command acted on");
endmodule // acgc_ctrl_monitor
bind acgc_ctrl acgc_ctrl_monitor #(
  .SELF_CAL_CYCLES(SELF_CAL_CYCLES),
  .SYS_CAL_CYCLES(SYS_CAL_CYCLES)
) i_mon (
  .clock_in, .rst_in, .cmd_valid_in, .cmd_byte_in, .reg_we_in, .reg_sel_in,
  .reg_wdata_in, .gpio_out, .gpio_oe_out, .converter_setup_out, .trim_control_out,
  .pin_control_out, .reference_buffer_enable_out, .signal_buffer_enable_out,
  .oscillator_select_out, .single_shot_select_out, .busy_out, .soc_out, .scgc_out
);
`default_nettype wire

/* File: bench/acgc_mod_model.sv */
// modulator model feeding raw samples on the link clock
`timescale 1ns/1ns
`default_nettype none
module acgc_mod_model (
  // link clock and sample strobe
  output logic link_clock_out,
  output logic sample_valid_out,
  output logic [23:0] sample_out
);
  initial begin
    link_clock_out = 1'b0;
    sample_valid_out = 1'b0;
    sample_out = 24'h000000;
    #3;
    forever begin
      #7 link_clock_out = 1'b1;
      #8 link_clock_out = 1'b0;
    end
  end
  // one strobe, then data no longer holds the old value
  task automatic send(input logic [23:0] v);
    @(posedge link_clock_out);
    sample_valid_out <= 1'b1;
    sample_out <= v;
    @(posedge link_clock_out);
    sample_valid_out <= 1'b0;
    sample_out <= ~v;
  endtask
endmodule // acgc_mod_model
`default_nettype wire

/* File: bench/acgc_ctrl_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acgc_ctrl_test;
  localparam int unsigned SELF_N = 200;
  localparam int unsigned SYS_N = 100;
  logic clock_in, rst_in, cmd_valid_in, reg_we_in, lclk, smp_v;
  logic [7:0] cmd_byte_in;
  logic [2:0] reg_sel_in;
  logic [23:0] reg_wdata_in, smp;
  logic [3:0] gpio_in, gpio_out, gpio_oe_out, gpio_level_out;
  logic [7:0] converter_setup_out, trim_control_out, pin_control_out;
  logic [2:0] rate_out;
  logic reference_buffer_enable_out, signal_buffer_enable_out, oscillator_select_out;
  logic outside_clock_select_out, single_shot_select_out, power_down_out, busy_out;
  logic result_valid_out, result_settled_out;
  logic [23:0] soc_out, sgc_out, scoc_out, scgc_out, result_out;
  logic [95:0] co;
  logic [23:0] cv [4];
  logic [23:0] res_q [$];
  logic set_q [$];
  int n_mismatch, checks_done, cyc;
  assign co = {scgc_out, scoc_out, sgc_out, soc_out};
  // ==========
  // design, modulator model, clock
  acgc_ctrl #(.SELF_CAL_CYCLES(SELF_N), .SYS_CAL_CYCLES(SYS_N)) i_dut (
    .clock_in, .rst_in, .link_clock_in(lclk), .cmd_valid_in, .cmd_byte_in, .reg_we_in,
    .reg_sel_in, .reg_wdata_in, .sample_valid_in(smp_v), .sample_in(smp), .gpio_in,
    .gpio_out, .gpio_oe_out, .converter_setup_out, .trim_control_out, .pin_control_out,
    .rate_out, .reference_buffer_enable_out, .signal_buffer_enable_out,
    .oscillator_select_out, .outside_clock_select_out, .single_shot_select_out,
    .power_down_out, .busy_out, .gpio_level_out, .soc_out, .sgc_out, .scoc_out,
    .scgc_out, .result_valid_out, .result_settled_out, .result_out);
  acgc_mod_model i_mod (.link_clock_out(lclk), .sample_valid_out(smp_v), .sample_out(smp));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (result_valid_out === 1'b1) begin
      res_q.push_back(result_out);
      set_q.push_back(result_settled_out);
    end
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ==========
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_near(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if ((^g === 1'bx) || (g + 32'h2 < e) || (g > e + 32'h2)) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [23:0] d);
    @(posedge clock_in);
    reg_we_in <= 1'b1;
    reg_sel_in <= sel;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_we_in <= 1'b0;
    @(posedge clock_in);
    #1;
  endtask
  task automatic cmd(input logic [7:0] b);
    @(posedge clock_in);
    cmd_valid_in <= 1'b1;
    cmd_byte_in <= b;
    @(posedge clock_in);
    cmd_valid_in <= 1'b0;
    @(posedge clock_in);
    #1;
  endtask
  // calibration with an ignored command and write inside it
  task automatic cal_run(input logic [7:0] b, input logic [31:0] n);
    logic [31:0] k;
    cmd(b);
    cmd(8'ha0);
    wr(acgc_pkg::SEL_PIN, 24'h000000);
    k = 32'h6;
    while (busy_out === 1'b1 && k < 32'd1000) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    chk_near("cal_cycles", n, k);
    chk("pin_kept", 24'h000054, 24'(pin_control_out));
  endtask
  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (res_q.size() < n && k < 300) begin
      @(posedge clock_in);
      k++;
    end
    chk("results", 24'(n), 24'(res_q.size()));
  endtask
  // ==========
  // main sequence
  initial begin
    cv = '{24'hffee1d, 24'h81cb5b, 24'h00007e, 24'hbfd345};
    {rst_in, cmd_valid_in, reg_we_in} = 3'h4;
    {cmd_byte_in, reg_sel_in, reg_wdata_in, gpio_in} = '0;
    {n_mismatch, checks_done, cyc} = '0;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    #1;
    chk("coefs", 24'h0, co[23:0] | co[47:24] | co[71:48] | co[95:72]);
    chk("trim", 24'h00000f, 24'(trim_control_out));
    chk("pins", 24'h0, 24'({pin_control_out, gpio_oe_out, busy_out}));
    wr(acgc_pkg::SEL_PIN, 24'h0000f1);
    chk("gpio", 24'h0000f1, 24'({gpio_oe_out, gpio_out}));
    wr(acgc_pkg::SEL_PIN, 24'h000054);
    chk("gpio", 24'h000054, 24'({gpio_oe_out, gpio_out}));
    @(posedge clock_in) gpio_in <= 4'ha;
    repeat (6) @(posedge clock_in);
    chk("gpio_level", 24'h00000a, 24'(gpio_level_out));
    for (int i = 0; i < 5; i++) begin
      wr(acgc_pkg::SEL_SETUP, 24'(1 << i));
      chk("setup", 24'(1 << i), 24'({signal_buffer_enable_out, reference_buffer_enable_out,
        outside_clock_select_out, oscillator_select_out,
        single_shot_select_out}));
    end
    for (int i = 0; i < 4; i++) begin
      wr(3'(i + 3), cv[i]);
    end
    wr(3'h7, 24'h123456);
    for (int i = 0; i < 4; i++) begin
      chk("coef", cv[i], co[i*24 +: 24]);
    end
    wr(acgc_pkg::SEL_TRIM, 24'h00000c);
    wr(acgc_pkg::SEL_PIN, 24'h000054);
    cal_run(8'h90, SELF_N);
    chk("self_gain", acgc_pkg::GAIN_UNITY, scgc_out);
    chk("self_off", 24'h000000, scoc_out);
    wr(acgc_pkg::SEL_TRIM, 24'h000008);
    cal_run(8'ha0, SYS_N);
    chk("sys_off", 24'h000000, soc_out);
    wr(acgc_pkg::SEL_TRIM, 24'h000000);
    cal_run(8'hb0, SYS_N);
    cmd(8'hd0);
    cmd(8'h10);
    chk("busy_refused", 24'h0, 24'(busy_out));
    wr(acgc_pkg::SEL_TRIM, 24'h00000f);
    wr(acgc_pkg::SEL_SETUP, 24'h000001);
    cmd(8'h87);
    chk("rate", 24'h000007, 24'(rate_out));
    i_mod.send(24'h400000);
    wait_res(1);
    chk("shot_settled", 24'h1, 24'(set_q[0]));
    chk_near("raw_scale", 32'h266666, 32'(res_q[0]));
    wr(acgc_pkg::SEL_SETUP, 24'h000000);
    cmd(8'h87);
    for (int i = 0; i < 4; i++) begin
      i_mod.send(24'h400000);
    end
    wait_res(5);
    for (int i = 1; i < 5; i++) begin
      chk("cont_settled", 24'(i == 4), 24'(set_q[i]));
    end
    cmd(8'h88);
    chk("power_down", 24'h1, 24'(power_down_out));
    tally_and_finish();
  end
endmodule // acgc_ctrl_test
`default_nettype wire
